// ### inc/mac_mode_irq_consts.vh
// Offsets, field positions and reset values of the mode and enable registers
// Assumes a 32-bit APB with byte addresses
`ifndef MAC_MODE_IRQ_CONSTS_VH
`define MAC_MODE_IRQ_CONSTS_VH

`define ADDR_NET_MODE 12'h030
`define ADDR_IRQ_EN 12'h038
`define ADDR_IRQ_STATUS 12'h028
`define ADDR_RX_STATE 12'h0F0

`define MODE_FORCE_COLL 12
`define MODE_OPMODE_LO 10
`define MODE_ALL_MCAST 7
`define MODE_PROMISC 6
`define MODE_BACKOFF_HOLD 5
`define MODE_PASS_BAD 3
`define MODE_RX_START 1
`define MODE_WR_MASK 32'h0000_1CEA
`define MODE_RESET 32'h0000_0000

`define OPMODE_NORMAL 2'h0
`define OPMODE_MAC_LOOP 2'h1

`define IEN_NORMAL_SUM 16
`define IEN_ABNORMAL_SUM 15
`define IEN_FATAL_BUS 13
`define IEN_TIMER 11
`define IEN_RX_WDOG 9
`define IEN_RX_STOP 8
`define IEN_RX_UNAVAIL 7
`define IEN_RX_DONE 6
`define IEN_TX_UFLOW 5
`define IEN_TX_JABBER 3
`define IEN_TX_DONE 0
`define IEN_WR_MASK 32'h0001_ABEF
`define IEN_RESET 32'h0000_0000

`define NORMAL_CLASS_MASK 32'h0000_0045
`define ABNORMAL_CLASS_MASK 32'h0000_2BAA

`endif

// ### core/mac_mode_irq_regs.v
// Mode register, interrupt enable and latched status with one irq output
// Assumes APB master on clk_sys; MAC events are one-cycle pulses on clk_sys
//
// What this block does
// - Force-collision bit makes every transmit attempt collide; resets to zero.
// - Operating mode 00 normal, 01 MAC loop-back; 10 and 11 reserved.
// - All-multicast bit makes receive filter accept every multicast packet.
// - Promiscuous accepts any good packet; else only matching destination.
// - Back-off hold pauses back-off counting while carrier is active.
// - Pass-bad keeps bad packets passing address filter; else discard.
// - Clearing receive start stops receiver after current frame completes.
// - Stopped receiver still takes pause and wake-up frames when enabled.
// - Setting receive start puts receiver in running state; resets zero.
// - Normal summary enable passes normal sources with their own enables.
// - Abnormal summary enable passes abnormal sources with own enables.
// - Fatal bus error irq needs its enable and abnormal summary.
// - Timer expiry irq needs its enable and abnormal summary.
// - Receive watchdog irq needs its enable and abnormal summary.
// - Receive stopped irq needs its enable and abnormal summary.
// - Receive descriptor unavailable irq needs enable and abnormal summary.
// - Receive completed irq needs its enable and normal summary.
// - Transmit underflow irq needs its enable and abnormal summary.
// - Transmit jabber irq needs its enable and abnormal summary.
// - Transmit completed irq needs its enable and normal summary.
// - Status flags stay set until software writes one to them.
`timescale 1ns/1ns
`default_nettype none
`include "mac_mode_irq_consts.vh"

module mac_mode_irq_regs (
    input wire clk_sys,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [31:0] eventPulse,
    input wire frameBusy,
    input wire carrierSense,
    input wire pauseFrameEn,
    input wire wakeFrameEn,
    output reg forceCollision,
    output reg macLoopback,
    output reg allMulticast,
    output reg promiscuous,
    output reg backoffPause,
    output reg passBad,
    output reg rxRunning,
    output reg rxControlFramesOnly,
    output reg irqOut
);
    localparam [2:0] RX_STOP = 3'b001;
    localparam [2:0] RX_RUN = 3'b010;
    localparam [2:0] RX_FINISH = 3'b100;

    reg [31:0] modeReg_r;
    reg [31:0] ienReg_r;
    reg [31:0] status_r;
    reg [2:0] rxState_r;
    reg [2:0] rxState_nxt;
    reg [31:0] rdMux;
    wire [31:0] statusClr;
    wire [31:0] classGate;
    wire setupPhase;
    wire wrStrobe;
    wire addrOk;

    // Register selects and stored mode fields
    wire selMode;
    wire selIen;
    wire selStatus;
    wire selRxState;
    wire [31:0] modeWrData;
    wire [31:0] ienWrData;
    wire fcBit;
    wire [1:0] opModeSel;
    wire mcastBit;
    wire promiscBit;
    wire backoffBit;
    wire passBadBit;
    wire rxStopNxt;

    // Interrupt gating
    wire normalSum;
    wire abnormalSum;
    wire gateFatalBus;
    wire gateTimer;
    wire gateRxWdog;
    wire gateRxStop;
    wire gateRxUnavail;
    wire gateRxDone;
    wire gateTxUflow;
    wire gateTxJabber;
    wire gateTxDone;
    reg [31:0] srcArmed;
    wire [31:0] srcFire;
    wire [31:0] srcMask;

    // Decoded register selects
    assign setupPhase = psel && !penable;
    assign wrStrobe = psel && penable && pready && pwrite;
    assign selMode = paddr == `ADDR_NET_MODE;
    assign selIen = paddr == `ADDR_IRQ_EN;
    assign selStatus = paddr == `ADDR_IRQ_STATUS;
    assign selRxState = paddr == `ADDR_RX_STATE;
    assign addrOk = selMode || selIen || selStatus || selRxState;

    // Write-one clear mask for the status flags
    assign statusClr = (wrStrobe && selStatus) ? pwdata : 32'h0000_0000;

    // Reserved positions never reach storage
    assign modeWrData = pwdata & `MODE_WR_MASK;
    assign ienWrData = pwdata & `IEN_WR_MASK;

    // Mode fields as stored
    assign fcBit = modeReg_r[`MODE_FORCE_COLL];
    assign opModeSel = modeReg_r[`MODE_OPMODE_LO+1:`MODE_OPMODE_LO];
    assign mcastBit = modeReg_r[`MODE_ALL_MCAST];
    assign promiscBit = modeReg_r[`MODE_PROMISC];
    assign backoffBit = modeReg_r[`MODE_BACKOFF_HOLD];
    assign passBadBit = modeReg_r[`MODE_PASS_BAD];

    // Summary enables
    assign normalSum = ienReg_r[`IEN_NORMAL_SUM];
    assign abnormalSum = ienReg_r[`IEN_ABNORMAL_SUM];

    // Summary enable fans out over its class of sources
    assign classGate =
        ({32{normalSum}} & `NORMAL_CLASS_MASK) |
        ({32{abnormalSum}} & `ABNORMAL_CLASS_MASK);

    // Each named source needs its own enable and its class summary
    assign gateFatalBus = ienReg_r[`IEN_FATAL_BUS] && abnormalSum;
    assign gateTimer = ienReg_r[`IEN_TIMER] && abnormalSum;
    assign gateRxWdog = ienReg_r[`IEN_RX_WDOG] && abnormalSum;
    assign gateRxStop = ienReg_r[`IEN_RX_STOP] && abnormalSum;
    assign gateRxUnavail = ienReg_r[`IEN_RX_UNAVAIL] && abnormalSum;
    assign gateRxDone = ienReg_r[`IEN_RX_DONE] && normalSum;
    assign gateTxUflow = ienReg_r[`IEN_TX_UFLOW] && abnormalSum;
    assign gateTxJabber = ienReg_r[`IEN_TX_JABBER] && abnormalSum;
    assign gateTxDone = ienReg_r[`IEN_TX_DONE] && normalSum;
    assign srcMask = `NORMAL_CLASS_MASK | `ABNORMAL_CLASS_MASK;

    // Per-source arming; named sources spelled out over the fan-out
    always @* begin
        srcArmed = ienReg_r & classGate;
        srcArmed[`IEN_FATAL_BUS] = gateFatalBus;
        srcArmed[`IEN_TIMER] = gateTimer;
        srcArmed[`IEN_RX_WDOG] = gateRxWdog;
        srcArmed[`IEN_RX_STOP] = gateRxStop;
        srcArmed[`IEN_RX_UNAVAIL] = gateRxUnavail;
        srcArmed[`IEN_RX_DONE] = gateRxDone;
        srcArmed[`IEN_TX_UFLOW] = gateTxUflow;
        srcArmed[`IEN_TX_JABBER] = gateTxJabber;
        srcArmed[`IEN_TX_DONE] = gateTxDone;
    end

    // Zero-wait-state APB slave: ready in the access phase
    always @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPhase;
        end
    end

    // Unmapped addresses are refused in the access phase
    always @(posedge clk_sys) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setupPhase && !addrOk;
        end
    end

    // Read data captured at setup, stands through the access phase
    always @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= rdMux;
        end
    end

    // Reserved bits are held zero in storage, so they read zero
    always @* begin
        rdMux = 32'h0000_0000;
        if (selMode) begin
            rdMux = modeReg_r;
        end
        if (selIen) begin
            rdMux = ienReg_r;
        end
        if (selStatus) begin
            rdMux = status_r;
        end
        if (selRxState) begin
            rdMux = {29'h0000_0000, rxState_r};
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            modeReg_r <= `MODE_RESET;
        end else if (wrStrobe && selMode) begin
            modeReg_r <= modeWrData;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            ienReg_r <= `IEN_RESET;
        end else if (wrStrobe && selIen) begin
            ienReg_r <= ienWrData;
        end
    end

    // Set beats a write-one clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : gStatus
            always @(posedge clk_sys) begin
                if (reset || !srcMask[i]) begin
                    status_r[i] <= 1'b0;
                end else if (eventPulse[i]) begin
                    status_r[i] <= 1'b1;
                end else if (statusClr[i]) begin
                    status_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // A flag fires only while it is armed
    generate
        for (i = 0; i < 32; i = i + 1) begin : gFire
            assign srcFire[i] = status_r[i] && srcArmed[i];
        end
    endgenerate

    // Receive processor state
    always @* begin
        rxState_nxt = rxState_r;
        case (rxState_r)
            RX_STOP: begin
                if (modeReg_r[`MODE_RX_START]) begin
                    rxState_nxt = RX_RUN;
                end
            end
            RX_RUN: begin
                if (!modeReg_r[`MODE_RX_START]) begin
                    rxState_nxt = frameBusy ? RX_FINISH : RX_STOP;
                end
            end
            RX_FINISH: begin
                if (modeReg_r[`MODE_RX_START]) begin
                    rxState_nxt = RX_RUN;
                end else if (!frameBusy) begin
                    rxState_nxt = RX_STOP;
                end
            end
            default: rxState_nxt = RX_STOP;
        endcase
    end

    assign rxStopNxt = rxState_nxt == RX_STOP;

    // Receive processor state register
    always @(posedge clk_sys) begin
        if (reset) begin
            rxState_r <= RX_STOP;
        end else begin
            rxState_r <= rxState_nxt;
        end
    end

    // Collide on every attempt, test use
    always @(posedge clk_sys) begin
        if (reset) begin
            forceCollision <= 1'b0;
        end else begin
            forceCollision <= fcBit;
        end
    end

    // Reserved codes give no loop-back
    always @(posedge clk_sys) begin
        if (reset) begin
            macLoopback <= 1'b0;
        end else begin
            macLoopback <= opModeSel == `OPMODE_MAC_LOOP;
        end
    end

    // Accept every multicast packet
    always @(posedge clk_sys) begin
        if (reset) begin
            allMulticast <= 1'b0;
        end else begin
            allMulticast <= mcastBit;
        end
    end

    // Accept any good packet
    always @(posedge clk_sys) begin
        if (reset) begin
            promiscuous <= 1'b0;
        end else begin
            promiscuous <= promiscBit;
        end
    end

    // Back-off counter held while carrier is up
    always @(posedge clk_sys) begin
        if (reset) begin
            backoffPause <= 1'b0;
        end else begin
            backoffPause <= backoffBit && carrierSense;
        end
    end

    // Keep bad packets that pass the address filter
    always @(posedge clk_sys) begin
        if (reset) begin
            passBad <= 1'b0;
        end else begin
            passBad <= passBadBit;
        end
    end

    // Running also covers the frame still finishing
    always @(posedge clk_sys) begin
        if (reset) begin
            rxRunning <= 1'b0;
        end else begin
            rxRunning <= !rxStopNxt;
        end
    end

    // Control frames still taken while stopped
    always @(posedge clk_sys) begin
        if (reset) begin
            rxControlFramesOnly <= 1'b0;
        end else begin
            rxControlFramesOnly <= rxStopNxt &&
                (pauseFrameEn || wakeFrameEn);
        end
    end

    // Level output, follows the armed flags
    always @(posedge clk_sys) begin
        if (reset) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |srcFire;
        end
    end
endmodule
`default_nettype wire

// ### verification/apb_host.sv
// Host software model: plain APB master, one word per transfer
// Assumes pready is sampled at rising edges of clk_sys
`timescale 1ns/1ns
`default_nettype none
module apb_host (
    input wire logic clk_sys,
    output var logic psel, penable, pwrite,
    output var logic [11:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready, pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Holds the request until pready; gives up after 20 edges
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e,
        output logic hung);
        int n;
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        hung = pready !== 1'b1;
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ### verification/mac_mode_irq_regs_checker.sv
// Port-level properties of the mode and interrupt enable registers
// Bound to mac_mode_irq_regs; one clock domain
`timescale 1ns/1ns
`default_nettype none
module mac_mode_irq_regs_checker (
    input wire logic clk_sys, reset, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, eventPulse,
    input wire logic pready, pslverr, frameBusy, carrierSense,
    input wire logic forceCollision, macLoopback, allMulticast,
    input wire logic promiscuous, backoffPause, passBad, rxRunning,
    input wire logic irqOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic setup = psel && !penable;
    wire logic wrAcc = psel && penable && pwrite;
    wire logic wrMode = wrAcc && paddr == 12'h030;
    wire logic noMap = paddr != 12'h030 && paddr != 12'h038 &&
        paddr != 12'h028 && paddr != 12'h0F0;
    sequence s_stopIdle;
        wrMode && !pwdata[1] ##1 (!frameBusy && !wrMode)[*3];
    endsequence
    sequence s_clrQuiet;
        wrAcc && paddr == 12'h028 && pwdata == 32'hFFFF_FFFF &&
            eventPulse == 32'h0000_0000 ##1 (eventPulse == 32'h0000_0000)[*3];
    endsequence
    property p_rdy; setup |=> pready; endproperty
    property p_err; setup && noMap |=> pslverr && pready; endproperty
    property p_mode;
        logic [31:0] d;
        (wrMode, d = pwdata) |-> ##2 forceCollision == d[12] &&
            allMulticast == d[7] && promiscuous == d[6] && passBad == d[3];
    endproperty
    property p_loop;
        logic [1:0] m;
        (wrMode, m = pwdata[11:10]) |-> ##2 macLoopback == (m == 2'h1);
    endproperty
    property p_boff; backoffPause |-> $past(carrierSense); endproperty
    property p_run; wrMode && pwdata[1] |-> ##2 rxRunning; endproperty
    property p_stop; s_stopIdle |-> !rxRunning; endproperty
    property p_clr; s_clrQuiet |-> !irqOut; endproperty
    property p_ienOff;
        wrAcc && paddr == 12'h038 && pwdata == 32'h0000_0000 |-> ##3 !irqOut;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    a_err: assert property (p_err) else $error("unmapped not refused");
    a_mode: assert property (p_mode) else $error("mode bit wrong");
    a_loop: assert property (p_loop) else $error("loopback wrong");
    a_boff: assert property (p_boff) else $error("backoff no carrier");
    a_run: assert property (p_run) else $error("rx not running");
    a_stop: assert property (p_stop) else $error("rx not stopped");
    a_clr: assert property (p_clr) else $error("irq after clear");
    a_ienOff: assert property (p_ienOff) else $error("irq unmasked");
endmodule
bind mac_mode_irq_regs mac_mode_irq_regs_checker chk (.clk_sys, .reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .eventPulse, .pready,
    .pslverr, .frameBusy, .carrierSense, .forceCollision, .macLoopback,
    .allMulticast, .promiscuous, .backoffPause, .passBad, .rxRunning,
    .irqOut);
`default_nettype wire

// ### verification/mac_mode_irq_regs_tb.sv
// Self-checking bench for the mode and interrupt enable registers
// Host side is apb_host; MAC side levels and pulses come from here
`timescale 1ns/1ns
`default_nettype none
`include "mac_mode_irq_consts.vh"
module mac_mode_irq_regs_tb;
    logic clk_sys = 1'b0, reset = 1'b1, frameBusy = 1'b0;
    logic carrierSense = 1'b0, pauseFrameEn = 1'b0, wakeFrameEn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, forceCollision;
    logic macLoopback, allMulticast, promiscuous, backoffPause;
    logic passBad, rxRunning, rxControlFramesOnly, irqOut;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, eventPulse = 32'h0000_0000;
    int errors = 0, check_count = 0;
    always #25 clk_sys = ~clk_sys;
    apb_host host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    mac_mode_irq_regs dut (.clk_sys, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .eventPulse,
        .frameBusy, .carrierSense, .pauseFrameEn, .wakeFrameEn,
        .forceCollision, .macLoopback, .allMulticast, .promiscuous,
        .backoffPause, .passBad, .rxRunning, .rxControlFramesOnly, .irqOut);
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d, checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        logic [31:0] q;
        logic e, hung;
        host.xfer(w, a, d, q, e, hung);
        if (hung) begin
            errors++;
            finish_test;
        end
        if (!w) begin
            chk("read data", d, q);
            chk("slave error", a == 12'h0FC, e);
        end
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_reset;
        xfer(1'b0, `ADDR_NET_MODE, 32'h0000_0000);
        xfer(1'b0, `ADDR_IRQ_EN, 32'h0000_0000);
        xfer(1'b0, 12'h0FC, 32'h0000_0000);
    endtask
    task automatic t_mode;
        xfer(1'b1, `ADDR_NET_MODE, 32'hFFFF_FFFD);
        xfer(1'b0, `ADDR_NET_MODE, 32'h0000_1CE8);
        chk("filter", 4'hF, {forceCollision, allMulticast, promiscuous,
            passBad});
        chk("loopback", 1'b0, macLoopback);
        xfer(1'b1, `ADDR_NET_MODE, 32'h0000_0420);
        chk("loopback", 1'b1, macLoopback);
        chk("filter", 4'h0, {forceCollision, allMulticast, promiscuous,
            passBad});
        carrierSense <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("backoff", 1'b1, backoffPause);
        xfer(1'b1, `ADDR_NET_MODE, 32'h0000_0000);
        chk("backoff", 1'b0, backoffPause);
        chk("loopback", 1'b0, macLoopback);
        carrierSense <= 1'b0;
    endtask
    task automatic t_rx;
        {frameBusy, pauseFrameEn} <= 2'b11;
        xfer(1'b1, `ADDR_NET_MODE, 32'h0000_0002);
        chk("running", 1'b1, rxRunning);
        chk("control only", 1'b0, rxControlFramesOnly);
        xfer(1'b0, `ADDR_RX_STATE, 32'h0000_0002);
        xfer(1'b1, `ADDR_NET_MODE, 32'h0000_0000);
        chk("finishing", 1'b1, rxRunning);
        xfer(1'b0, `ADDR_RX_STATE, 32'h0000_0004);
        frameBusy <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("running", 1'b0, rxRunning);
        xfer(1'b0, `ADDR_RX_STATE, 32'h0000_0001);
        chk("control only", 1'b1, rxControlFramesOnly);
        {pauseFrameEn, wakeFrameEn} <= 2'b01;
        repeat (3) @(posedge clk_sys);
        chk("control only", 1'b1, rxControlFramesOnly);
    endtask
    task automatic t_irq;
        int src[9] = '{13, 11, 9, 8, 7, 6, 5, 3, 0};
        logic [31:0] m, s;
        foreach (src[i]) begin
            m = 32'h0000_0001 << src[i];
            s = (src[i] == 6 || src[i] == 0) ? 32'h0001_0000 : 32'h0000_8000;
            xfer(1'b1, `ADDR_IRQ_EN, m | (s ^ 32'h0001_8000));
            eventPulse <= m;
            @(posedge clk_sys);
            eventPulse <= 32'h0000_0000;
            repeat (3) @(posedge clk_sys);
            chk("irq other class", 1'b0, irqOut);
            xfer(1'b1, `ADDR_IRQ_EN, m | s);
            chk("irq", 1'b1, irqOut);
            xfer(1'b1, `ADDR_IRQ_STATUS, 32'h0000_0000);
            chk("irq held", 1'b1, irqOut);
            xfer(1'b0, `ADDR_IRQ_STATUS, m);
            xfer(1'b1, `ADDR_IRQ_STATUS, 32'hFFFF_FFFF);
            chk("irq cleared", 1'b0, irqOut);
        end
        xfer(1'b1, `ADDR_IRQ_EN, 32'h0000_0000);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset;
        t_mode;
        t_rx;
        t_irq;
        finish_test;
    end
endmodule
`default_nettype wire
